// file: verilog/pin_reset_sleep_state_control.sv
// Pin state control through reset, sleep entry, sleep and wake
`timescale 1ns/1ns
`include "pin_sleep_consts.svh"
module pin_reset_sleep_state_control (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Power manager requests
  input wire logic sleep_req,
  input wire logic wake_req,
  // Software control
  input wire logic rdh_clear,
  input wire logic status_clear,
  input wire logic static_mem_float_in_sleep,
  input wire logic card_float_in_sleep,
  input wire logic dir_we,
  input wire logic [`PIN_W-1:0] dir_wdata,
  input wire logic level_we,
  input wire logic [`PIN_W-1:0] level_wdata,
  // Normal output data
  input wire logic [`GPIO_W-1:0] gpio_out_data,
  input wire logic [`CARD_W-1:0] card_out_data,
  // Memory controller strobes
  input wire logic mc_write_strobe_n,
  input wire logic mc_output_strobe_n,
  input wire logic mc_boot_chip_select_n,
  // Pins
  input wire logic [`PIN_W-1:0] pin_in,
  output logic [`PIN_W-1:0] pin_out,
  output logic [`PIN_W-1:0] pin_oe,
  output logic [`PIN_W-1:0] pin_in_en,
  output logic [`PIN_W-1:0] pin_pullup_en,
  // Core read data
  output logic [`PIN_W-1:0] pin_rd_data,
  // Status
  output logic [`PIN_W-1:0] pin_direction_register,
  output logic [`PIN_W-1:0] pin_sleep_level_registers,
  output logic [`STATUS_W-1:0] sleep_status_register,
  output logic in_sleep
);

  sleep_ctrl_if ctl ();

  pin_sleep_pkg::sleep_state_type state_q;
  pin_sleep_pkg::sleep_state_type state_d;
  logic [`PREP_CNT_W-1:0] prep_cnt_q;
  logic [`PREP_CNT_W-1:0] prep_cnt_d;
  logic rdh_q;
  logic rdh_d;
  logic slept_q;
  logic slept_d;
  logic in_sleep_q;
  logic [`PIN_W-1:0] dir_q;
  logic [`PIN_W-1:0] level_q;

  logic enter_sleep;
  logic prep_done;
  logic leave_sleep;
  logic [`MEM_W-1:0] mem_strobes;
  logic [`PIN_W-1:0] normal_out;
  logic [`PIN_W-1:0] float_mask;
  logic [`PIN_W-1:0] force_mask;

  // Sequencer events
  assign enter_sleep = (state_q == pin_sleep_pkg::st_run) & sleep_req;
  assign prep_done = (state_q == pin_sleep_pkg::st_prep) & (prep_cnt_q == '0);
  assign leave_sleep = (state_q == pin_sleep_pkg::st_asleep) & wake_req;

  // Normal pin data; memory strobes follow the controller while running
  assign mem_strobes[`WRITE_STROBE_BIT] = mc_write_strobe_n;
  assign mem_strobes[`OUTPUT_STROBE_BIT] = mc_output_strobe_n;
  assign mem_strobes[`BOOT_CS_BIT] = mc_boot_chip_select_n;
  assign normal_out = {card_out_data, mem_strobes, gpio_out_data};

  // Float groups in sleep, or park strobes high first
  assign float_mask = ({`PIN_W{static_mem_float_in_sleep}} & `MEM_MASK)
    | ({`PIN_W{card_float_in_sleep}} & `CARD_MASK);
  assign force_mask = {`PIN_W{~static_mem_float_in_sleep}} & `MEM_MASK;

  always_comb begin
    state_d = state_q;
    prep_cnt_d = prep_cnt_q;
    unique case (state_q)
      pin_sleep_pkg::st_run: begin
        if (sleep_req) begin
          state_d = pin_sleep_pkg::st_prep;
          prep_cnt_d = `PREP_CNT_W'(`PREP_CYCLES - 1);
        end
      end
      pin_sleep_pkg::st_prep: begin
        if (prep_done) begin
          state_d = pin_sleep_pkg::st_asleep;
        end else begin
          prep_cnt_d = prep_cnt_q - `PREP_CNT_W'(1);
        end
      end
      pin_sleep_pkg::st_asleep: begin
        if (wake_req) begin
          state_d = pin_sleep_pkg::st_run;
        end
      end
      default: begin
        state_d = pin_sleep_pkg::st_run;
      end
    endcase
  end

  // Sleep entry setting the hold beats a clear in the same cycle
  assign rdh_d = enter_sleep ? 1'b1 : (rdh_clear ? 1'b0 : rdh_q);
  // Wake flag for software; the set beats a clear in the same cycle
  assign slept_d = leave_sleep ? 1'b1 : (status_clear ? 1'b0 : slept_q);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= pin_sleep_pkg::st_run;
      prep_cnt_q <= '0;
      rdh_q <= `RDH_RST;
      slept_q <= 1'b0;
      in_sleep_q <= 1'b0;
    end else begin
      state_q <= state_d;
      prep_cnt_q <= prep_cnt_d;
      rdh_q <= rdh_d;
      slept_q <= slept_d;
      in_sleep_q <= (state_d == pin_sleep_pkg::st_asleep);
    end
  end

  // Memory control direction bits stay set whatever software writes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dir_q <= `DIR_RST;
      level_q <= `LEVEL_RST;
    end else begin
      if (dir_we) begin
        dir_q <= dir_wdata | `MEM_MASK;
      end
      if (level_we) begin
        level_q <= level_wdata;
      end
    end
  end

  // Flags for the pin logic
  assign ctl.read_disable_hold = rdh_q;
  assign ctl.prep = (state_q == pin_sleep_pkg::st_prep);
  assign ctl.asleep = (state_q == pin_sleep_pkg::st_asleep);

  sleep_pin_bank bank (
    .sys_clk(sys_clk),
    .rst(rst),
    .ctl(ctl),
    .normal_out(normal_out),
    .dir(dir_q),
    .level(level_q),
    .float_mask(float_mask),
    .force_mask(force_mask),
    .pin_out_q(pin_out),
    .pin_oe_q(pin_oe)
  );

  pin_input_gate gate (
    .sys_clk(sys_clk),
    .rst(rst),
    .ctl(ctl),
    .pin_in(pin_in),
    .pin_in_en_q(pin_in_en),
    .pin_pullup_en_q(pin_pullup_en),
    .pin_rd_data_q(pin_rd_data)
  );

  // Status readback from flops
  assign pin_direction_register = dir_q;
  assign pin_sleep_level_registers = level_q;
  assign sleep_status_register[`STATUS_RDH_BIT] = rdh_q;
  assign sleep_status_register[`STATUS_SLEPT_BIT] = slept_q;
  assign in_sleep = in_sleep_q;

endmodule : pin_reset_sleep_state_control

// file: verilog/pin_sleep_consts.svh
// Widths, pin positions, reset values and timing counts of the pin sleep control
`ifndef PIN_SLEEP_CONSTS_SVH
`define PIN_SLEEP_CONSTS_SVH

// Pin bank layout: GPIO low, static memory control, then card control
`define GPIO_W 16
`define MEM_W 3
`define CARD_W 4
`define PIN_W 23
`define MEM_LSB 16
`define CARD_LSB 19

// Bit positions inside the static memory control group
`define WRITE_STROBE_BIT 0
`define OUTPUT_STROBE_BIT 1
`define BOOT_CS_BIT 2

// Masks over the whole pin vector
`define MEM_MASK 23'h070000
`define CARD_MASK 23'h780000

// Reset values
`define DIR_RST 23'h070000
`define LEVEL_RST 23'h000000
`define RDH_RST 1'h1
`define PULLUP_RST 23'h7FFFFF
`define STATUS_W 2
`define STATUS_RDH_BIT 1
`define STATUS_SLEPT_BIT 0

// Sleep entry: strobes parked high for this long, in ns, at 8 ns per cycle
`define PREP_TIME_NS 16
`define CLK_PERIOD_NS 8
`define PREP_CYCLES ((`PREP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PREP_CNT_W 2

`endif

// file: verilog/pin_sleep_pkg.sv
// Types shared by the pin sleep control modules
package pin_sleep_pkg;

  typedef enum logic [1:0] {
    st_run,
    st_prep,
    st_asleep
  } sleep_state_type;

endpackage : pin_sleep_pkg

// file: verilog/sleep_ctrl_if.sv
// Sleep sequencing flags passed from the sequencer to the pin logic
`timescale 1ns/1ns
interface sleep_ctrl_if;
  logic read_disable_hold;
  logic prep;
  logic asleep;

  modport seq (output read_disable_hold, output prep, output asleep);
  modport pins (input read_disable_hold, input prep, input asleep);
endinterface : sleep_ctrl_if

// file: verilog/sleep_pin_bank.sv
// Output and enable selection for every pin across run, sleep entry and sleep
`timescale 1ns/1ns
`include "pin_sleep_consts.svh"
module sleep_pin_bank (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Sequencer flags
  sleep_ctrl_if.pins ctl,
  // Pin sources
  input wire logic [`PIN_W-1:0] normal_out,
  input wire logic [`PIN_W-1:0] dir,
  input wire logic [`PIN_W-1:0] level,
  input wire logic [`PIN_W-1:0] float_mask,
  input wire logic [`PIN_W-1:0] force_mask,
  // Pins
  output logic [`PIN_W-1:0] pin_out_q,
  output logic [`PIN_W-1:0] pin_oe_q
);

  logic [`PIN_W-1:0] sleep_oe;
  logic [`PIN_W-1:0] sleep_out;
  logic [`PIN_W-1:0] prep_out;
  logic [`PIN_W-1:0] pin_out_d;
  logic [`PIN_W-1:0] pin_oe_d;

  // Inputs never drive, floated groups never drive
  assign sleep_oe = dir & ~float_mask;
  assign sleep_out = level;
  // Memory strobes parked high while the controller hands over
  assign prep_out = (level & ~force_mask) | force_mask;
  assign pin_out_d = ctl.asleep ? sleep_out : (ctl.prep ? prep_out : normal_out);
  assign pin_oe_d = (ctl.asleep | ctl.prep) ? sleep_oe : dir;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_out_q <= `LEVEL_RST;
      pin_oe_q <= '0;
    end else begin
      pin_out_q <= pin_out_d;
      pin_oe_q <= pin_oe_d;
    end
  end

endmodule : sleep_pin_bank

// file: verilog/pin_input_gate.sv
// Input path gating and pull-up control driven by the read-disable-hold flag
`timescale 1ns/1ns
`include "pin_sleep_consts.svh"
module pin_input_gate (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Sequencer flags
  sleep_ctrl_if.pins ctl,
  // Pins
  input wire logic [`PIN_W-1:0] pin_in,
  output logic [`PIN_W-1:0] pin_in_en_q,
  output logic [`PIN_W-1:0] pin_pullup_en_q,
  // Core side
  output logic [`PIN_W-1:0] pin_rd_data_q
);

  logic [`PIN_W-1:0] open_mask;

  assign open_mask = {`PIN_W{~ctl.read_disable_hold}};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_in_en_q <= '0;
      pin_pullup_en_q <= `PULLUP_RST;
      pin_rd_data_q <= '0;
    end else begin
      pin_in_en_q <= open_mask;
      // Only reset turns pull-ups back on; sleep re-setting the hold leaves them off
      pin_pullup_en_q <= pin_pullup_en_q & ~open_mask;
      pin_rd_data_q <= pin_in & open_mask;
    end
  end

endmodule : pin_input_gate

// file: testbench/pin_sleep_properties.sv
// Concurrent checks on the pin sleep control top ports
`timescale 1ns/1ns
`include "pin_sleep_consts.svh"
module pin_sleep_properties (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Watched controls
  input wire logic static_mem_float_in_sleep,
  input wire logic card_float_in_sleep,
  input wire logic [`GPIO_W-1:0] gpio_out_data,
  // Watched outputs
  input wire logic [`PIN_W-1:0] pin_out,
  input wire logic [`PIN_W-1:0] pin_oe,
  input wire logic [`PIN_W-1:0] pin_in_en,
  input wire logic [`PIN_W-1:0] pin_pullup_en,
  input wire logic [`PIN_W-1:0] pin_direction_register,
  input wire logic [`PIN_W-1:0] pin_sleep_level_registers,
  input wire logic [`STATUS_W-1:0] sleep_status_register,
  input wire logic in_sleep
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Pins settle on sleep values one edge after the state turns asleep
  sequence settled_s;
    in_sleep && $past(in_sleep);
  endsequence

  a_reset_inputs: assert property ($past(rst) |-> pin_oe == 23'h0 &&
    pin_direction_register == `DIR_RST) else $error("pins not inputs after reset");
  a_reset_pullups: assert property ($past(rst) |-> pin_in_en == 23'h0 &&
    pin_pullup_en == `PULLUP_RST) else $error("pull-ups or buffers wrong after reset");
  a_rdh_opens: assert property ($fell(sleep_status_register[1]) |=>
    pin_in_en == 23'h7FFFFF && pin_pullup_en == 23'h0) else $error("inputs not opened");
  a_pullups_stay_off: assert property (pin_pullup_en == 23'h0 |=>
    pin_pullup_en == 23'h0) else $error("pull-ups came back");
  a_sleep_sets_rdh: assert property ($rose(in_sleep) |->
    sleep_status_register[1] && pin_in_en == 23'h0) else $error("hold flag not set");
  a_sleep_no_drive: assert property (settled_s |->
    (pin_oe & ~$past(pin_direction_register)) == 23'h0) else $error("input pin driven");
  a_sleep_level: assert property (settled_s |->
    ((pin_out ^ $past(pin_sleep_level_registers)) & pin_oe) == 23'h0)
    else $error("sleep level wrong");
  a_wake_blocked: assert property (sleep_status_register[1] &&
    $past(sleep_status_register[1]) |-> pin_in_en == 23'h0) else $error("input open early");
  a_mem_float: assert property (settled_s |-> (pin_oe & `MEM_MASK) ==
    ($past(static_mem_float_in_sleep) ? 23'h0 : `MEM_MASK)) else $error("memory pins wrong");
  a_strobes_parked: assert property ($rose(in_sleep) |->
    (pin_oe & pin_out & `MEM_MASK) == ($past(static_mem_float_in_sleep) ? 23'h0 : `MEM_MASK))
    else $error("strobes not high");
  a_card_float: assert property ((settled_s and $past(card_float_in_sleep)) |->
    (pin_oe & `CARD_MASK) == 23'h0) else $error("card pins driven");
  a_wake_restore: assert property ($fell(in_sleep) |=>
    pin_oe == $past(pin_direction_register)
    && ((pin_out[15:0] ^ $past(gpio_out_data)) & pin_oe[15:0]) == 16'h0)
    else $error("normal drive not restored");

  c_float_sleep: cover property ($rose(in_sleep) && static_mem_float_in_sleep);
  c_wake: cover property ($fell(in_sleep));
  c_rdh_clear: cover property ($fell(sleep_status_register[1]));
endmodule : pin_sleep_properties

bind pin_reset_sleep_state_control pin_sleep_properties u_props (.*);

// file: testbench/tb.sv
// Directed bench for reset, sleep entry, sleep and wake of the pin control
`timescale 1ns/1ns
`include "pin_sleep_consts.svh"
module tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic sleep_req = 1'b0, wake_req = 1'b0, rdh_clear = 1'b0, status_clear = 1'b0;
  logic static_mem_float_in_sleep = 1'b0, card_float_in_sleep = 1'b0;
  logic dir_we = 1'b0, level_we = 1'b0;
  logic [22:0] dir_wdata = 23'h0, level_wdata = 23'h0, pin_in = 23'h0;
  logic [15:0] gpio_out_data = 16'h0;
  logic [3:0] card_out_data = 4'h0;
  logic mc_write_strobe_n = 1'b1, mc_output_strobe_n = 1'b1, mc_boot_chip_select_n = 1'b1;
  logic [22:0] pin_out, pin_oe, pin_in_en, pin_pullup_en, pin_rd_data;
  logic [22:0] pin_direction_register, pin_sleep_level_registers;
  logic [1:0] sleep_status_register;
  logic in_sleep;
  int mismatches = 0;
  int n_tests = 0;

  pin_reset_sleep_state_control DUT (
    .sys_clk(sys_clk),
    .rst(rst),
    .sleep_req(sleep_req),
    .wake_req(wake_req),
    .rdh_clear(rdh_clear),
    .status_clear(status_clear),
    .static_mem_float_in_sleep(static_mem_float_in_sleep),
    .card_float_in_sleep(card_float_in_sleep),
    .dir_we(dir_we),
    .dir_wdata(dir_wdata),
    .level_we(level_we),
    .level_wdata(level_wdata),
    .gpio_out_data(gpio_out_data),
    .card_out_data(card_out_data),
    .mc_write_strobe_n(mc_write_strobe_n),
    .mc_output_strobe_n(mc_output_strobe_n),
    .mc_boot_chip_select_n(mc_boot_chip_select_n),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe(pin_oe),
    .pin_in_en(pin_in_en),
    .pin_pullup_en(pin_pullup_en),
    .pin_rd_data(pin_rd_data),
    .pin_direction_register(pin_direction_register),
    .pin_sleep_level_registers(pin_sleep_level_registers),
    .sleep_status_register(sleep_status_register),
    .in_sleep(in_sleep)
  );

  always #4 sys_clk = ~sys_clk;

  task chk(input string nm, input logic [22:0] e, input logic [22:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task give_verdict();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  task do_reset();
    @(posedge sys_clk) rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    chk("dir", `DIR_RST, pin_direction_register);
    chk("pullup", `PULLUP_RST, pin_pullup_en);
    chk("in_en", 23'h0, pin_in_en);
    chk("status", 23'h2, sleep_status_register);
    chk("out", `LEVEL_RST, pin_out);
    chk("rd_data", 23'h0, pin_rd_data);
    @(posedge sys_clk);
    #1;
    chk("oe", `DIR_RST, pin_oe);
    $display("test reset done");
  endtask : do_reset

  // Clears the hold and slept flags together; both opens take two edges
  task clear_flags();
    @(posedge sys_clk) begin
      rdh_clear <= 1'b1;
      status_clear <= 1'b1;
    end
    @(posedge sys_clk) begin
      rdh_clear <= 1'b0;
      status_clear <= 1'b0;
    end
    @(posedge sys_clk);
    #1;
    chk("in_en", 23'h7FFFFF, pin_in_en);
    chk("pullup", 23'h0, pin_pullup_en);
    chk("status", 23'h0, sleep_status_register);
  endtask : clear_flags

  task run(input logic fs, input logic fp, input logic [22:0] v);
    logic [22:0] d, l, oe_e;
    int n;
    d = v | `MEM_MASK;
    l = {v[11:0], v[22:12]};
    oe_e = d & ~({23{fs}} & `MEM_MASK) & ~({23{fp}} & `CARD_MASK);
    n = 0;
    @(posedge sys_clk) begin
      dir_we <= 1'b1;
      level_we <= 1'b1;
      dir_wdata <= v;
      level_wdata <= l;
      pin_in <= v;
      gpio_out_data <= ~v[15:0];
      {card_out_data, mc_boot_chip_select_n, mc_output_strobe_n, mc_write_strobe_n} <= ~v[22:16];
      static_mem_float_in_sleep <= fs;
      card_float_in_sleep <= fp;
    end
    // Hold clear lands on the sleep entry edge: the set must win
    @(posedge sys_clk) begin
      dir_we <= 1'b0;
      level_we <= 1'b0;
      sleep_req <= 1'b1;
      rdh_clear <= 1'b1;
    end
    @(posedge sys_clk) begin
      sleep_req <= 1'b0;
      rdh_clear <= 1'b0;
    end
    #1;
    chk("level", l, pin_sleep_level_registers);
    chk("dir", d, pin_direction_register);
    while (in_sleep !== 1'b1 && n < 8) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk("in_sleep", 23'h1, {22'h0, in_sleep});
    chk("strobes", fs ? 23'h0 : `MEM_MASK, pin_oe & pin_out & `MEM_MASK);
    chk("rdh", 23'h1, {22'h0, sleep_status_register[1]});
    @(posedge sys_clk);
    #1;
    chk("sleep oe", oe_e, pin_oe);
    chk("sleep out", l & oe_e, pin_out & oe_e);
    chk("pullup", 23'h0, pin_pullup_en);
    repeat (4) @(posedge sys_clk);
    wake_req <= 1'b1;
    @(posedge sys_clk) wake_req <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk("wake oe", d, pin_oe);
    chk("in_sleep", 23'h0, {22'h0, in_sleep});
    chk("wake out", ~v & d, pin_out & d);
    chk("wake in_en", 23'h0, pin_in_en);
    chk("status", 23'h3, sleep_status_register);
    clear_flags();
    chk("rd_data", v, pin_rd_data);
    $display("test sleep fs %0b fp %0b done", fs, fp);
  endtask : run

  initial begin
    do_reset();
    clear_flags();
    run(1'b0, 1'b0, 23'h30FF0F);
    run(1'b1, 1'b1, 23'h4A5A96);
    run(1'b0, 1'b1, 23'h25C3A5);
    run(1'b1, 1'b0, 23'h1B6E4D);
    do_reset();
    give_verdict();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge sys_clk);
    mismatches++;
    give_verdict();
  end
endmodule : tb
